/* design/aec_pkg.sv */
// Shared constants, register map and controller state type for the engine register link.
package aec_pkg;
   // Internal engine register addresses.
   localparam logic [7:0] ADDR_CONV_SLOT = 8'h00;
   localparam logic [7:0] ADDR_ENGINE_CONTROL = 8'h01;
   localparam logic [7:0] ADDR_TIME_STAMP_CONTROL = 8'h02;
   localparam logic [7:0] ADDR_TIME_BASE_CONTROL = 8'h03;
   localparam logic [7:0] ADDR_GAIN_CONSTANT = 8'h04;
   localparam logic [7:0] ADDR_OFFSET_CONSTANT = 8'h05;
   localparam logic [7:0] ADDR_LAST = 8'h05;
   // Writable bit masks; zero bits are reserved.
   localparam logic [15:0] MASK_FULL = 16'hFFFF;
   localparam logic [15:0] MASK_GAIN = 16'h7FFF;
   localparam logic [15:0] MASK_OFFSET = 16'h3FFF;
   localparam logic [15:0] RESET_REG = 16'h0000;
   // Gain field layout: one integer bit above fourteen fraction bits.
   localparam int GAIN_INT_POS = 14;
   localparam int GAIN_FRAC_BITS = 14;
   localparam int OFFSET_BITS = 14;
   // Correction arithmetic.
   localparam logic [16:0] ROUND_TERM = 17'h0_0002;
   localparam logic [16:0] RESULT_MAX = 17'h0_3FFF;
   // Conversion command word: calibrated correction select bit.
   localparam int CONV_CAL_POS = 0;
   // Controller APB register byte offsets.
   localparam logic [11:0] APB_COMMAND = 12'h000;
   localparam logic [11:0] APB_STATUS = 12'h004;
   localparam logic [11:0] APB_RESULT = 12'h008;
   // Command word field positions.
   localparam int CMD_ADDR_POS = 16;
   localparam int CMD_WRITE_POS = 24;
   localparam int CMD_ENGINE_POS = 25;
   // Status bit positions.
   localparam int ST_BUSY = 0;
   localparam int ST_RESULT_VALID = 1;
   localparam int ST_CAL_REFUSED = 2;
   localparam int ST_LOADED0 = 3;
   localparam int ST_LOADED1 = 4;
   localparam int RESULT_ENGINE_POS = 16;

   typedef enum logic [1:0] {
      AEC_IDLE = 2'b00,
      AEC_SEND = 2'b01,
      AEC_WAIT = 2'b10
   } aec_state_t;

   // Returns the writable bit mask of an internal register address.
   function automatic logic [15:0] reg_mask(input logic [7:0] addr);
      logic [15:0] m;
      m = 16'h0000;
      if (addr == ADDR_GAIN_CONSTANT)
      begin
         m = MASK_GAIN;
      end
      else if (addr == ADDR_OFFSET_CONSTANT)
      begin
         m = MASK_OFFSET;
      end
      else if (addr >= ADDR_ENGINE_CONTROL && addr <= ADDR_LAST)
      begin
         m = MASK_FULL;
      end
      return m;
   endfunction : reg_mask
endpackage : aec_pkg

/* design/aec_if.sv */
// Command and result message link between controller and converter engines.
`timescale 1ns/10ps
interface aec_if;
   logic cmd_valid;
   logic cmd_ready;
   logic cmd_engine;
   logic cmd_write;
   logic [7:0] cmd_addr;
   logic [15:0] cmd_data;
   logic rsp_valid;
   logic rsp_engine;
   logic [15:0] rsp_data;

   modport ctrl (
      output cmd_valid, cmd_engine, cmd_write, cmd_addr, cmd_data,
      input cmd_ready, rsp_valid, rsp_engine, rsp_data
   );
   modport dev (
      input cmd_valid, cmd_engine, cmd_write, cmd_addr, cmd_data,
      output cmd_ready, rsp_valid, rsp_engine, rsp_data
   );
endinterface : aec_if

/* design/aec_engine_dev.sv */
// Two converter engines with message-reached internal registers and result correction.
`timescale 1ns/10ps
module aec_engine_dev (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Message link.
   aec_if.dev link,
   // Raw 12-bit samples from each converter.
   input wire logic [1:0][11:0] raw_sample
);
   wire take = link.cmd_valid & ce;
   wire addr_mapped = (link.cmd_addr >= aec_pkg::ADDR_ENGINE_CONTROL) &&
                      (link.cmd_addr <= aec_pkg::ADDR_LAST);
   wire conv_cmd = link.cmd_write && (link.cmd_addr == aec_pkg::ADDR_CONV_SLOT);
   wire want_rsp = take & (~link.cmd_write | conv_cmd);
   wire [15:0] wr_value = link.cmd_data & aec_pkg::reg_mask(link.cmd_addr);
   wire [2:0] idx = link.cmd_addr[2:0];
   wire calibrated = link.cmd_data[aec_pkg::CONV_CAL_POS];

   logic [15:0] rd_data [0:1];
   logic [15:0] conv_res [0:1];
   logic rsp_valid_q;
   logic rsp_engine_q;
   logic [15:0] rsp_data_q;

   assign link.cmd_ready = ce;
   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_engine = rsp_engine_q;
   assign link.rsp_data = rsp_data_q;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_engine
         logic [15:0] reg_q [1:5];
         wire sel = take && (link.cmd_engine == 1'(g));
         wire wr_hit = sel & link.cmd_write & addr_mapped;
         wire [15:0] gain_q = reg_q[4];
         wire [15:0] offset_q = reg_q[5];
         wire [13:0] raw14 = {raw_sample[g], 2'b00};
         wire [28:0] product = 29'(gain_q[aec_pkg::GAIN_INT_POS:0]) * 29'(raw14);
         wire [14:0] scaled = product[28:aec_pkg::GAIN_FRAC_BITS];
         wire [16:0] off_ext = {{3{offset_q[aec_pkg::OFFSET_BITS-1]}},
                                offset_q[aec_pkg::OFFSET_BITS-1:0]};
         wire [16:0] sum = {2'b00, scaled} + off_ext + aec_pkg::ROUND_TERM;
         wire sum_neg = sum[16];
         wire sum_big = !sum_neg && (sum > aec_pkg::RESULT_MAX);
         wire [15:0] corrected = sum_neg ? 16'h0000 :
                                 sum_big ? aec_pkg::RESULT_MAX[15:0] : sum[15:0];

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               for (int i = 1; i <= 5; i++)
               begin
                  reg_q[i] <= aec_pkg::RESET_REG;
               end
            end
            else if (ce && wr_hit)
            begin
               reg_q[idx] <= wr_value;
            end
         end

         assign rd_data[g] = addr_mapped ? reg_q[idx] : 16'h0000;
         assign conv_res[g] = calibrated ? corrected : {2'b00, raw14};
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rsp_valid_q <= 1'b0;
         rsp_engine_q <= 1'b0;
         rsp_data_q <= 16'h0000;
      end
      else if (ce)
      begin
         rsp_valid_q <= want_rsp;
         if (want_rsp)
         begin
            rsp_engine_q <= link.cmd_engine;
            rsp_data_q <= conv_cmd ? conv_res[link.cmd_engine] :
                          rd_data[link.cmd_engine];
         end
      end
   end
endmodule : aec_engine_dev

/* design/aec_ctrl.sv */
// Command controller: APB slave that sends engine register and conversion messages.
`timescale 1ns/10ps
module aec_ctrl (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Message link.
   aec_if.ctrl link
);
   aec_pkg::aec_state_t state_q;
   aec_pkg::aec_state_t state_d;
   logic [25:0] cmd_q;
   logic result_valid_q;
   logic refused_q;
   logic [1:0] gain_ld_q;
   logic [1:0] off_ld_q;
   logic [16:0] result_q;

   wire access = psel & penable & ce;
   wire hit_cmd = paddr == aec_pkg::APB_COMMAND;
   wire hit_st = paddr == aec_pkg::APB_STATUS;
   wire hit_res = paddr == aec_pkg::APB_RESULT;
   wire mapped = hit_cmd | hit_st | hit_res;
   wire busy = state_q != aec_pkg::AEC_IDLE;
   wire [7:0] new_addr = pwdata[aec_pkg::CMD_ADDR_POS +: 8];
   wire new_wr = pwdata[aec_pkg::CMD_WRITE_POS];
   wire new_eng = pwdata[aec_pkg::CMD_ENGINE_POS];
   wire new_conv = new_wr && (new_addr == aec_pkg::ADDR_CONV_SLOT);
   wire new_cal = new_conv && pwdata[aec_pkg::CONV_CAL_POS];
   wire loaded = gain_ld_q[new_eng] & off_ld_q[new_eng];
   wire cal_block = new_cal & ~loaded;
   wire cmd_wr = access & pwrite & hit_cmd & ~busy;
   wire launch = cmd_wr & ~cal_block;
   wire wr_gain = launch && new_wr && (new_addr == aec_pkg::ADDR_GAIN_CONSTANT);
   wire wr_off = launch && new_wr && (new_addr == aec_pkg::ADDR_OFFSET_CONSTANT);
   wire expects_rsp = ~cmd_q[aec_pkg::CMD_WRITE_POS] ||
                      (cmd_q[aec_pkg::CMD_ADDR_POS +: 8] == aec_pkg::ADDR_CONV_SLOT);
   wire res_rd = access & ~pwrite & hit_res;
   wire rsp_take = link.rsp_valid & ce;
   wire [31:0] status_word = {27'h000_0000, off_ld_q[1] & gain_ld_q[1],
                              off_ld_q[0] & gain_ld_q[0], refused_q, result_valid_q, busy};

   assign pready = ce;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = hit_st ? status_word :
                   hit_res ? {15'h0000, result_q} : 32'h0000_0000;
   assign link.cmd_valid = state_q == aec_pkg::AEC_SEND;
   assign link.cmd_engine = cmd_q[aec_pkg::CMD_ENGINE_POS];
   assign link.cmd_write = cmd_q[aec_pkg::CMD_WRITE_POS];
   assign link.cmd_addr = cmd_q[aec_pkg::CMD_ADDR_POS +: 8];
   assign link.cmd_data = cmd_q[15:0];

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         aec_pkg::AEC_IDLE:
         begin
            if (launch)
            begin
               state_d = aec_pkg::AEC_SEND;
            end
         end
         aec_pkg::AEC_SEND:
         begin
            if (link.cmd_ready)
            begin
               state_d = expects_rsp ? aec_pkg::AEC_WAIT : aec_pkg::AEC_IDLE;
            end
         end
         aec_pkg::AEC_WAIT:
         begin
            if (link.rsp_valid)
            begin
               state_d = aec_pkg::AEC_IDLE;
            end
         end
         default:
         begin
            state_d = aec_pkg::AEC_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= aec_pkg::AEC_IDLE;
         cmd_q <= 26'h000_0000;
         gain_ld_q <= 2'b00;
         off_ld_q <= 2'b00;
      end
      else if (ce)
      begin
         state_q <= state_d;
         if (launch)
         begin
            cmd_q <= pwdata[25:0];
         end
         if (wr_gain)
         begin
            gain_ld_q[new_eng] <= 1'b1;
         end
         if (wr_off)
         begin
            off_ld_q[new_eng] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_valid_q <= 1'b0;
         refused_q <= 1'b0;
         result_q <= 17'h0_0000;
      end
      else if (ce)
      begin
         if (rsp_take)
         begin
            result_valid_q <= 1'b1;
            result_q <= {link.rsp_engine, link.rsp_data};
         end
         else if (res_rd)
         begin
            result_valid_q <= 1'b0;
         end
         if (cmd_wr && cal_block)
         begin
            refused_q <= 1'b1;
         end
         else if (access && pwrite && hit_st && pwdata[aec_pkg::ST_CAL_REFUSED])
         begin
            refused_q <= 1'b0;
         end
      end
   end
endmodule : aec_ctrl

/* bench/aec_assertions.sv */
// Concurrent checks on the engine message link.
`timescale 1ns/10ps
module aec_assertions (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Message link.
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic cmd_engine,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   input wire logic rsp_valid,
   input wire logic rsp_engine,
   input wire logic [15:0] rsp_data
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire take = cmd_valid && cmd_ready;
   wire rd_take = take && !cmd_write;
   wire conv_take = take && cmd_write && (cmd_addr == aec_pkg::ADDR_CONV_SLOT);
   wire wr_take = take && cmd_write && (cmd_addr != aec_pkg::ADDR_CONV_SLOT);
   wire resv_rd = rd_take && (cmd_addr == 8'h00 || cmd_addr > aec_pkg::ADDR_LAST);
   AST_READ_ANSWER: assert property (rd_take |=> rsp_valid)
      else $error("read not answered");
   AST_ENGINE_SEL: assert property ((rd_take || conv_take) |=> rsp_engine == $past(cmd_engine))
      else $error("wrong engine answered");
   AST_WRITE_SILENT: assert property (wr_take |=> !rsp_valid)
      else $error("register write answered");
   AST_RSP_PULSE: assert property (rsp_valid && cmd_ready |=> !rsp_valid)
      else $error("response longer than one cycle");
   AST_SERIAL: assert property ((rd_take || conv_take) |=> !cmd_valid)
      else $error("new message offered before response");
   AST_RESV_ZERO: assert property (resv_rd |=> rsp_valid && rsp_data == 16'h0000)
      else $error("reserved address read nonzero");
   AST_GAIN_RESV: assert property (rd_take && cmd_addr == 8'h04 |=> !rsp_data[15])
      else $error("gain reserved bit set");
   AST_OFF_RESV: assert property (rd_take && cmd_addr == 8'h05 |=> rsp_data[15:14] == 2'b00)
      else $error("offset reserved bits set");
   AST_RSP_HOLD: assert property (!rsp_valid |-> $stable(rsp_data) && $stable(rsp_engine))
      else $error("response changed without valid");
   C_READ: cover property (rd_take);
   C_WRITE: cover property (wr_take);
   C_CONV: cover property (conv_take && cmd_data[0]);
endmodule : aec_assertions

/* bench/adc_engine_calib_registers_tb_top.sv */
// Testbench for the engine register link with controller and engines.
`timescale 1ns/10ps
module adc_engine_calib_registers_tb_top;
   logic pclk, presetn, ce, psel, penable, pwrite, pslverr, pready, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0][11:0] raw_sample;
   int fails, n_checks;
   logic e1 [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   logic cv [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [15:0] gv [6] = '{16'h4000, 16'h2000, 16'h6000, 16'h6000, 16'h7FFF, 16'h0000};
   logic [15:0] ov [6] = '{16'h3FF0, 16'h0000, 16'h0005, 16'h0005, 16'h1FFF, 16'h2000};
   logic [11:0] rv [6] = '{12'h400, 12'h400, 12'h800, 12'hC00, 12'hFFF, 12'h001};
   aec_if link_if();
   aec_ctrl i_aec_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link_if.ctrl));
   aec_engine_dev i_aec_engine_dev (.pclk(pclk), .presetn(presetn), .ce(ce),
      .link(link_if.dev), .raw_sample(raw_sample));
   aec_assertions i_aec_assertions (.pclk(pclk), .presetn(presetn),
      .cmd_valid(link_if.cmd_valid), .cmd_ready(link_if.cmd_ready),
      .cmd_engine(link_if.cmd_engine), .cmd_write(link_if.cmd_write),
      .cmd_addr(link_if.cmd_addr), .cmd_data(link_if.cmd_data),
      .rsp_valid(link_if.rsp_valid), .rsp_engine(link_if.rsp_engine),
      .rsp_data(link_if.rsp_data));
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      n_checks++;
      if (got !== x)
         $display("[ERR] %s expected %h seen %h", nm, x, got);
      if (got !== x)
         fails++;
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic eng(input logic e, input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [31:0] q);
      logic [31:0] st;
      apb(1'b1, aec_pkg::APB_COMMAND, {6'h00, e, w, a, d}, st);
      st = 32'h0000_0001;
      while (st[aec_pkg::ST_BUSY] !== 1'b0) apb(1'b0, aec_pkg::APB_STATUS, 32'h0, st);
      apb(1'b0, aec_pkg::APB_RESULT, 32'h0, q);
   endtask : eng
   function automatic logic [15:0] calx(input logic [15:0] g, o, input logic [11:0] s);
      int v;
      v = ((int'(g[14:0]) * int'({s, 2'b00})) >>> 14) + int'($signed(o[13:0])) + 2;
      if (v < 0)
         v = 0;
      if (v > 16383)
         v = 16383;
      return v[15:0];
   endfunction : calx
   function automatic logic [15:0] pat(input logic e, input logic [7:0] a);
      return {2'b11, e, 5'h1F, a};
   endfunction : pat
   function automatic logic [15:0] msk(input logic [7:0] a);
      return (a == 8'h04) ? 16'h7FFF : ((a == 8'h05) ? 16'h3FFF : 16'hFFFF);
   endfunction : msk
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails++;
      $display("[ERR] watchdog expected finish seen hang");
      tally_and_finish();
   end
   initial
   begin
      {psel, penable, pwrite, presetn, err} = 5'h00;
      {paddr, pwdata, r} = '0;
      ce = 1'b1;
      raw_sample = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int e = 0; e < 2; e++)
         for (int a = 1; a < 6; a++)
         begin
            eng(e[0], 1'b0, a[7:0], 16'h0000, r);
            chk("reset reg", {15'h0, e[0], 16'h0000}, r);
         end
      apb(1'b1, aec_pkg::APB_COMMAND, 32'h0100_0001, r);
      apb(1'b0, aec_pkg::APB_STATUS, 32'h0, r);
      chk("refused cal", 32'h0000_0004, r);
      apb(1'b1, aec_pkg::APB_STATUS, 32'h0000_0004, r);
      apb(1'b0, aec_pkg::APB_STATUS, 32'h0, r);
      chk("status clear", 32'h0000_0000, r);
      $display("test reset and refusal done");
      for (int e = 0; e < 2; e++)
         for (int a = 1; a < 6; a++)
            eng(e[0], 1'b1, a[7:0], pat(e[0], a[7:0]), r);
      for (int e = 0; e < 2; e++)
         for (int a = 1; a < 6; a++)
         begin
            eng(e[0], 1'b0, a[7:0], 16'h0000, r);
            chk("reg", {15'h0, e[0], pat(e[0], a[7:0]) & msk(a[7:0])}, r);
         end
      apb(1'b0, aec_pkg::APB_STATUS, 32'h0, r);
      chk("loaded", 32'h0000_0018, r);
      foreach (gv[i])
      begin
         eng(1'b0, 1'b1, 8'h06 + 8'(i * 43), 16'hFFFF, r);
         eng(1'b0, 1'b0, 8'h06 + 8'(i * 43), 16'h0000, r);
         chk("reserved", 32'h0000_0000, r);
      end
      for (int a = 1; a < 6; a++)
      begin
         eng(1'b0, 1'b0, a[7:0], 16'h0000, r);
         chk("alias", {16'h0, pat(1'b0, a[7:0]) & msk(a[7:0])}, r);
      end
      $display("test registers done");
      apb(1'b1, aec_pkg::APB_COMMAND, 32'h0101_1234, r);
      ce <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("frozen send", 32'h0000_0001, {31'h0, link_if.cmd_valid});
      ce <= 1'b1;
      eng(1'b0, 1'b0, 8'h01, 16'h0000, r);
      chk("after freeze", 32'h0000_1234, r);
      foreach (gv[i])
      begin
         eng(e1[i], 1'b1, 8'h04, gv[i], r);
         eng(e1[i], 1'b1, 8'h05, ov[i], r);
         raw_sample[e1[i]] <= rv[i];
         eng(e1[i], 1'b1, 8'h00, {15'h0, cv[i]}, r);
         chk("conv", {15'h0, e1[i], cv[i] ? calx(gv[i], ov[i], rv[i])
            : {2'b00, rv[i], 2'b00}}, r);
      end
      for (int k = 0; k < 2; k++)
      begin
         raw_sample[k] <= 12'h400;
         eng(k[0], 1'b1, 8'h00, 16'h0000, r);
         chk("ref read", {15'h0, k[0], 16'h1000}, r);
         eng(k[0], 1'b1, 8'h04, 16'h4000, r);
         eng(k[0], 1'b1, 8'h00, 16'h0001, r);
         chk("mixed coef", {15'h0, k[0], calx(16'h4000, ov[4 + k], 12'h400)}, r);
         eng(k[0], 1'b1, 8'h05, 16'h0010, r);
         eng(k[0], 1'b1, 8'h00, 16'h0001, r);
         chk("new coef", {15'h0, k[0], calx(16'h4000, 16'h0010, 12'h400)}, r);
      end
      apb(1'b0, 12'h00C, 32'h0, r);
      chk("unmapped err", 32'h0000_0001, {31'h0, err});
      chk("unmapped data", 32'h0000_0000, r);
      $display("test conversions done");
      tally_and_finish();
   end
endmodule : adc_engine_calib_registers_tb_top
